// ===== hdl/l2w_defines.svh
// Purpose: Constants for the processor-bus write and termination block
// Assumes: 32-bit processor address, 64-bit data lanes, 32-byte lines
// Notes:   Design offsets, field positions and counts live here as macros; the bench repeats them as literals
`ifndef L2W_DEFINES_SVH
`define L2W_DEFINES_SVH

// Bus widths
`define L2W_ADDR_W     32
`define L2W_DATA_W     64

// Double-word index within a four-dword line
`define L2W_DW_LSB     3
`define L2W_DW_MSB     4
`define L2W_DW_W       2

// Line index bits that reach the cache array address
`define L2W_LINE_LSB   5
`define L2W_LINE_MSB   17
`define L2W_LINE_W     13
`define L2W_SRAM_AW    15

// Burst shape: last beat index for burst and single-beat transfers
`define L2W_LAST_BURST 2'h3
`define L2W_LAST_SINGLE 2'h0

// Buffer toward the system-bus side
`define L2W_FIFO_DEPTH 8
`define L2W_FIFO_W     96

`endif

// ===== hdl/l2w_pkg.sv
// Purpose: Types shared by the write/termination block and its buffer
// Assumes: l2w_defines.svh supplies the widths
// Notes:   State codes are Gray along idle, address, beat
`include "l2w_defines.svh"

package l2w_pkg;

  // Transaction sequencer states
  typedef enum logic [2:0] {
    L2W_IDLE      = 3'h0,
    L2W_ADDR      = 3'h1,
    L2W_BEAT      = 3'h3,
    L2W_MISS_PUSH = 3'h2,
    L2W_MISS_ACK  = 3'h6
  } l2w_state_e;

  // One write beat handed to the system-bus side
  typedef struct packed {
    logic [`L2W_ADDR_W-1:0] addr;
    logic [`L2W_DATA_W-1:0] data;
  } l2w_word_s;

endpackage

// ===== hdl/l2w_fifo.sv
// Purpose: Write buffer between the processor-bus sequencer and system bus
// Assumes: Single clock, asynchronous active-high reset, DEPTH a power of 2
// Notes:   out_valid is registered; in_ready falls as soon as it is full
`timescale 1ns/1ps
`default_nettype none

module l2w_fifo #(
  parameter int W     = 96,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] wr_ptr_nxt;
  logic [PW-1:0] rd_ptr_r;
  logic [PW-1:0] rd_ptr_nxt;
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic          valid_r;
  logic          valid_nxt;
  logic          do_wr;
  logic          do_rd;

  // Full and empty come from the count, never from pointer equality
  assign in_ready  = (count_r != CW'(DEPTH));
  assign out_valid = valid_r;
  assign out_data  = mem[rd_ptr_r];

  // Pointer and count update
  always_comb begin
    do_wr      = in_valid && in_ready;
    do_rd      = valid_r && out_ready;
    wr_ptr_nxt = do_wr ? PW'(wr_ptr_r + 1'b1) : wr_ptr_r;
    rd_ptr_nxt = do_rd ? PW'(rd_ptr_r + 1'b1) : rd_ptr_r;
    count_nxt  = count_r;
    if (do_wr && !do_rd) begin
      count_nxt = CW'(count_r + 1'b1);
    end else if (do_rd && !do_wr) begin
      count_nxt = CW'(count_r - 1'b1);
    end
    valid_nxt = (count_nxt != '0);
  end

  // State registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      valid_r  <= 1'b0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
      valid_r  <= valid_nxt;
    end
  end

  // Storage carries no reset; valid_r guards every read
  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

endmodule

`default_nettype wire

// ===== hdl/l2w_write_term.sv
// Purpose: Processor-bus slave for write transfers into the cache array
// Assumes: Processor bus is synchronous to core_clk; tag result valid with
//          the start strobe; all bus pins shown active high
// Notes:   Misses push each beat into a write buffer toward the system bus
//
// How it works
// - Pre-acknowledge exactly one clock after start
// - Array captures data the clock after address
// - Miss: hold acknowledge until write buffer takes data
// - Second clock on a hit: drive array, write-enable, no acknowledge
// - Burst hit: first acknowledge clock 3, three more follow
// - Each beat advances the internal array address
// - After last hit beat release array, drop acknowledge
// - Error dominates; retry without error; else normal
// - Pre-acknowledge on every write start; on a miss acknowledge comes two clocks later at the earliest
// - Error only passed through from system-bus report
// - Normal acknowledge means write data accepted
// - Every burst beat gets its own acknowledge
// - Single-beat hit acknowledged in clock 3
// - Beat addresses generated internally, bus address ignored
// - Critical dword first, wrapping within the line
`timescale 1ns/1ps
`default_nettype none
`include "l2w_defines.svh"

module l2w_write_term
  import l2w_pkg::*;
(
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     reset,
  // Processor request
  input  wire logic                     xfer_start_strobe,
  input  wire logic                     burst_attr,
  input  wire logic                     write_attr,
  input  wire logic                     invalidate_attr,
  input  wire logic [`L2W_ADDR_W-1:0]   proc_addr,
  input  wire logic [`L2W_DATA_W-1:0]   dword_data_lanes,
  // Tag lookup and system-side events
  input  wire logic                     tag_hit,
  input  wire logic                     sys_error,
  input  wire logic                     retry_req_in,
  // Processor termination
  output logic                          pre_acknowledge,
  output logic                          beat_acknowledge,
  output logic                          error_acknowledge,
  output logic                          transfer_retry_req,
  // Cache array control
  output logic [`L2W_SRAM_AW-1:0]       sram_addr,
  output logic                          sram_drive_en,
  output logic                          sram_write_input_enable,
  // Write buffer toward the system bus
  output logic                          sysq_valid,
  output l2w_word_s                     sysq_word,
  input  wire logic                     sysq_ready
);

  l2w_state_e                   st_r;
  l2w_state_e                   st_nxt;
  logic [`L2W_LINE_W-1:0]       line_r;
  logic [`L2W_LINE_W-1:0]       line_nxt;
  logic [`L2W_ADDR_W-1:0]       base_r;
  logic [`L2W_ADDR_W-1:0]       base_nxt;
  logic [`L2W_DW_W-1:0]         idx_r;
  logic [`L2W_DW_W-1:0]         idx_nxt;
  logic [`L2W_DW_W-1:0]         beat_r;
  logic [`L2W_DW_W-1:0]         beat_nxt;
  logic                         hit_r;
  logic                         hit_nxt;
  logic                         burst_r;
  logic                         burst_nxt;
  logic                         pre_r;
  logic                         pre_nxt;
  logic                         ack_r;
  logic                         ack_nxt;
  logic                         err_r;
  logic                         err_nxt;
  logic                         rty_r;
  logic                         rty_nxt;
  logic                         drv_r;
  logic                         drv_nxt;
  logic                         we_r;
  logic                         we_nxt;
  logic [`L2W_SRAM_AW-1:0]      addr_r;
  logic [`L2W_SRAM_AW-1:0]      addr_nxt;
  logic                         fifo_push;
  logic                         fifo_in_ready;
  l2w_word_s                    fifo_word;
  logic [`L2W_DW_W-1:0]         last_beat;

  // Wrapping dword within the line, critical word first
  function automatic logic [`L2W_DW_W-1:0] dw_at(
    input logic [`L2W_DW_W-1:0] start,
    input logic [`L2W_DW_W-1:0] step
  );
    dw_at = `L2W_DW_W'(start + step);
  endfunction

  // Outputs come straight from the sequencer flops
  assign pre_acknowledge         = pre_r;
  assign beat_acknowledge        = ack_r;
  assign error_acknowledge       = err_r;
  assign transfer_retry_req      = rty_r;
  assign sram_addr               = addr_r;
  assign sram_drive_en           = drv_r;
  assign sram_write_input_enable = we_r;

  assign last_beat = burst_r ? `L2W_LAST_BURST : `L2W_LAST_SINGLE;

  // Miss beat word: address built here, bus address never re-read
  assign fifo_word.addr = {base_r[`L2W_ADDR_W-1:`L2W_LINE_LSB],
                           dw_at(idx_r, beat_r),
                           base_r[`L2W_DW_LSB-1:0]};
  assign fifo_word.data = dword_data_lanes;

  // Sequencer next state; error outranks retry, retry outranks acknowledge
  always_comb begin
    st_nxt    = st_r;
    line_nxt  = line_r;
    base_nxt  = base_r;
    idx_nxt   = idx_r;
    beat_nxt  = beat_r;
    hit_nxt   = hit_r;
    burst_nxt = burst_r;
    addr_nxt  = addr_r;
    pre_nxt   = 1'b0;
    ack_nxt   = 1'b0;
    err_nxt   = 1'b0;
    rty_nxt   = 1'b0;
    drv_nxt   = 1'b0;
    we_nxt    = 1'b0;
    fifo_push = 1'b0;
    case (st_r)
      L2W_IDLE: begin
        if (xfer_start_strobe && write_attr) begin
          st_nxt    = L2W_ADDR;
          base_nxt  = proc_addr;
          line_nxt  = proc_addr[`L2W_LINE_MSB:`L2W_LINE_LSB];
          idx_nxt   = proc_addr[`L2W_DW_MSB:`L2W_DW_LSB];
          hit_nxt   = tag_hit;
          burst_nxt = burst_attr;
          beat_nxt  = '0;
          pre_nxt   = 1'b1;
          drv_nxt   = tag_hit;
          we_nxt    = tag_hit;
          addr_nxt  = {proc_addr[`L2W_LINE_MSB:`L2W_LINE_LSB],
                       proc_addr[`L2W_DW_MSB:`L2W_DW_LSB]};
        end
      end
      L2W_ADDR: begin
        if (hit_r) begin
          st_nxt   = L2W_BEAT;
          ack_nxt  = 1'b1;
          drv_nxt  = 1'b1;
          we_nxt   = burst_r;
          addr_nxt = {line_r, dw_at(idx_r, 2'h1)};
        end else begin
          st_nxt = L2W_MISS_PUSH;
        end
      end
      L2W_BEAT: begin
        if (beat_r == last_beat) begin
          st_nxt = L2W_IDLE;
        end else begin
          beat_nxt = `L2W_DW_W'(beat_r + 1'b1);
          ack_nxt  = 1'b1;
          drv_nxt  = 1'b1;
          we_nxt   = (beat_nxt != last_beat);
          addr_nxt = {line_r, dw_at(idx_r, `L2W_DW_W'(beat_r + 2'h2))};
        end
      end
      L2W_MISS_PUSH: begin
        if (sys_error) begin
          st_nxt  = L2W_IDLE;
          err_nxt = 1'b1;
        end else if (fifo_in_ready) begin
          fifo_push = 1'b1;
          ack_nxt   = 1'b1;
          st_nxt    = L2W_MISS_ACK;
        end
      end
      L2W_MISS_ACK: begin
        if (beat_r == last_beat) begin
          st_nxt = L2W_IDLE;
        end else begin
          beat_nxt = `L2W_DW_W'(beat_r + 1'b1);
          st_nxt   = L2W_MISS_PUSH;
        end
      end
      default: begin
        st_nxt = L2W_IDLE;
      end
    endcase
    // A retry from the arbitration side aborts any open transfer
    if (st_r != L2W_IDLE && retry_req_in && !err_nxt) begin
      st_nxt    = L2W_IDLE;
      rty_nxt   = 1'b1;
      ack_nxt   = 1'b0;
      pre_nxt   = 1'b0;
      drv_nxt   = 1'b0;
      we_nxt    = 1'b0;
      fifo_push = 1'b0;
    end
  end

  // Sequencer registers; every output comes up negated
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_r    <= L2W_IDLE;
      line_r  <= '0;
      base_r  <= '0;
      idx_r   <= '0;
      beat_r  <= '0;
      hit_r   <= 1'b0;
      burst_r <= 1'b0;
      addr_r  <= '0;
      pre_r   <= 1'b0;
      ack_r   <= 1'b0;
      err_r   <= 1'b0;
      rty_r   <= 1'b0;
      drv_r   <= 1'b0;
      we_r    <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      line_r  <= line_nxt;
      base_r  <= base_nxt;
      idx_r   <= idx_nxt;
      beat_r  <= beat_nxt;
      hit_r   <= hit_nxt;
      burst_r <= burst_nxt;
      addr_r  <= addr_nxt;
      pre_r   <= pre_nxt;
      ack_r   <= ack_nxt;
      err_r   <= err_nxt;
      rty_r   <= rty_nxt;
      drv_r   <= drv_nxt;
      we_r    <= we_nxt;
    end
  end

  // Miss data buffer; a stalled system side stalls the acknowledge once the buffer is full
  l2w_fifo #(
    .W     (`L2W_FIFO_W),
    .DEPTH (`L2W_FIFO_DEPTH)
  ) u_wbuf (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_valid  (fifo_push),
    .in_data   (fifo_word),
    .in_ready  (fifo_in_ready),
    .out_valid (sysq_valid),
    .out_data  (sysq_word),
    .out_ready (sysq_ready)
  );

  // Checks on the termination protocol
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  a_pre_ack_one: assert property (
    st_r == L2W_IDLE && xfer_start_strobe && write_attr
    |=> pre_r && !ack_r)
    else $error("pre-acknowledge not one clock after start");
  a_pre_then_ack: assert property (
    pre_r && hit_r && !retry_req_in |=> ack_r)
    else $error("hit pre-acknowledge not followed by acknowledge");
  a_clock2_array: assert property (
    pre_r |-> !ack_r && drv_r == hit_r && we_r == hit_r)
    else $error("array control wrong in second clock");
  a_burst_beats: assert property (
    pre_r && hit_r && burst_r ##1 !rty_r [*4]
    |-> $past(ack_r, 3) && $past(ack_r, 2) && $past(ack_r) && ack_r)
    else $error("hit burst beats not back to back");
  a_burst_release: assert property (
    st_r == L2W_BEAT && beat_r == `L2W_LAST_BURST && burst_r
    |=> !ack_r && !drv_r && !we_r)
    else $error("array not released after last beat");
  a_addr_advance: assert property (
    st_r == L2W_BEAT && we_r
    |-> addr_r[1:0] == `L2W_DW_W'($past(addr_r[1:0]) + 1'b1))
    else $error("array address did not advance");
  a_term_exclusive: assert property (
    !(ack_r && (err_r || rty_r)) && !(err_r && rty_r))
    else $error("overlapping termination encodings");
  a_err_cause: assert property (err_r |-> $past(sys_error))
    else $error("error without system-side report");
  a_miss_wait: assert property (
    st_r == L2W_MISS_PUSH && !fifo_in_ready |=> !ack_r)
    else $error("miss acknowledged before data taken");
  a_miss_accept: assert property (
    ack_r && !hit_r |-> $past(fifo_push))
    else $error("miss acknowledge without buffered data");
  a_idle_quiet: assert property (
    st_r == L2W_IDLE |-> !pre_r && !ack_r && !drv_r && !we_r)
    else $error("outputs active while idle");

endmodule

`default_nettype wire

// ===== tb/l2w_proc_model.sv
// Purpose: Processor-side master issuing write transfers to the block
// Assumes: Drives 1 ns after the rising edge, samples at the edge
// Notes:   Beat data is built from the address so the bench can predict it
`timescale 1ns/1ps
`default_nettype none

module l2w_proc_model (
  // Clock
  input  wire logic        core_clk,
  // Termination from the block
  input  wire logic        pre_acknowledge,
  input  wire logic        beat_acknowledge,
  input  wire logic        error_acknowledge,
  input  wire logic        transfer_retry_req,
  // Request to the block
  output logic             xfer_start_strobe,
  output logic             burst_attr,
  output logic             write_attr,
  output logic             invalidate_attr,
  output logic [31:0]      proc_addr,
  output logic [63:0]      dword_data_lanes
);
  int   beats_done;
  logic saw_pre, got_err, got_retry;

  // Bus idle at time zero
  initial begin
    xfer_start_strobe = 1'b0;
    burst_attr = 1'b0;
    write_attr = 1'b0;
    invalidate_attr = 1'b0;
    proc_addr = 32'h0;
    dword_data_lanes = 64'h0;
  end

  // One transfer; returns once all beats are acknowledged or it is ended; a read returns right after the start clock
  task automatic xfer(input logic [31:0] a, input logic bst, input logic wr);
    int   n, w;
    logic ack, err, rty;
    n = bst ? 4 : 1;
    w = 0;
    beats_done = 0;
    saw_pre = 1'b0;
    got_err = 1'b0;
    got_retry = 1'b0;
    @(posedge core_clk);
    #1;
    proc_addr = a;
    burst_attr = bst;
    write_attr = wr;
    invalidate_attr = wr;
    dword_data_lanes = {a, 32'h0};
    xfer_start_strobe = 1'b1;
    @(posedge core_clk);
    #1;
    xfer_start_strobe = 1'b0; // One clock only
    while (wr && beats_done < n && w < 400) begin
      @(posedge core_clk);
      ack = beat_acknowledge;
      err = error_acknowledge;
      rty = transfer_retry_req;
      if (!saw_pre && pre_acknowledge === 1'b1) saw_pre = 1'b1;
      #1;
      w++;
      if (err === 1'b1) begin // Error wins over the rest
        got_err = 1'b1;
        break;
      end
      if (rty === 1'b1) begin
        got_retry = 1'b1;
        break;
      end
      if (ack === 1'b1) begin
        beats_done++;
        if (beats_done < n) dword_data_lanes = {a, 32'(beats_done)};
      end
    end
    // Bus given up: released lines no longer show the old value
    dword_data_lanes = ~dword_data_lanes;
    proc_addr = ~a;
    write_attr = 1'b0;
    burst_attr = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb/l2w_write_term_tb.sv
// Purpose: Self-checking bench for the write and termination block
// Assumes: Processor model drives the request side
// Notes:   All bench inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none

module l2w_write_term_tb;
  import l2w_pkg::*;
  logic core_clk = 1'b0, reset = 1'b1, tag_hit = 1'b0, sys_error = 1'b0;
  logic retry_req_in = 1'b0, sysq_ready = 1'b0;
  logic xfer_start_strobe, burst_attr, write_attr, invalidate_attr;
  logic [31:0] proc_addr;
  logic [63:0] dword_data_lanes;
  logic pre_acknowledge, beat_acknowledge, error_acknowledge;
  logic transfer_retry_req, sram_drive_en, sram_write_input_enable;
  logic sysq_valid;
  logic [14:0] sram_addr;
  l2w_word_s sysq_word;
  int mismatches = 0, samples_checked = 0, cycles = 0;

  l2w_write_term uut (.core_clk, .reset, .xfer_start_strobe, .burst_attr,
    .write_attr, .invalidate_attr, .proc_addr, .dword_data_lanes, .tag_hit,
    .sys_error, .retry_req_in, .pre_acknowledge, .beat_acknowledge,
    .error_acknowledge, .transfer_retry_req, .sram_addr, .sram_drive_en,
    .sram_write_input_enable, .sysq_valid, .sysq_word, .sysq_ready);

  l2w_proc_model pm (.core_clk, .pre_acknowledge, .beat_acknowledge,
    .error_acknowledge, .transfer_retry_req, .xfer_start_strobe, .burst_attr,
    .write_attr, .invalidate_attr, .proc_addr, .dword_data_lanes);

  // 50 ns clock
  initial begin
    forever #25 core_clk = ~core_clk;
  end

  task automatic close_out;
    $display("compared %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard, far above the hundred or so cycles the run needs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic chk_bit(string n, logic e, logic g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic chk_val(string n, logic [95:0] e, logic [95:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask

  // Acknowledge and array outputs packed for idle checks
  function automatic logic [95:0] outs();
    return {90'h0, pre_acknowledge, beat_acknowledge, error_acknowledge,
            transfer_retry_req, sram_drive_en, sram_write_input_enable};
  endfunction

  task automatic t_reset;
    repeat (2) tick();
    chk_val("outs in reset", 96'h0, outs());
    reset = 1'b0;
    tick();
    chk_val("outs after reset", 96'h0, outs());
  endtask

  // Hit walk, clock by clock, for burst or single beat
  task automatic t_hit(input logic [31:0] a, input logic bst);
    int c, last;
    logic [1:0] k;
    last = bst ? 6 : 3;
    tag_hit = 1'b1;
    fork
      pm.xfer(a, bst, 1'b1);
    join_none
    tick();
    for (c = 2; c <= last + 1; c++) begin
      tick();
      k = a[4:3] + 2'(c - 2);
      chk_bit("pre", c == 2, pre_acknowledge);
      chk_bit("ack", c >= 3 && c <= last, beat_acknowledge);
      chk_bit("err", 1'b0, error_acknowledge);
      chk_bit("drive", c <= last, sram_drive_en);
      chk_bit("we", c < last, sram_write_input_enable);
      if (c <= last) chk_val("addr", {a[17:5], k}, sram_addr);
    end
    wait fork;
    chk_val("hit beats", bst ? 96'h4 : 96'h1, pm.beats_done);
    chk_bit("pre seen", 1'b1, pm.saw_pre);
  endtask

  // Misses fill the buffer, the third burst stalls, then all drains
  task automatic t_miss_fill;
    logic [95:0] q[$];
    logic [95:0] e;
    logic [31:0] a[3];
    logic [31:0] b;
    int n;
    a = '{32'h0001_2358, 32'h0002_a460, 32'h0003_b4f0};
    tag_hit = 1'b0;
    for (n = 0; n < 2; n++) begin
      pm.xfer(a[n], 1'b1, 1'b1);
      chk_val("miss beats", 96'h4, pm.beats_done);
    end
    fork
      pm.xfer(a[2], 1'b1, 1'b1);
    join_none
    repeat (20) tick();
    chk_val("stalled beats", 96'h0, pm.beats_done);
    chk_bit("sysq valid", 1'b1, sysq_valid);
    sysq_ready = 1'b1;
    // Word shown now is the one taken at the coming edge
    for (n = 0; n < 80 && q.size() < 12; n++) begin
      if (sysq_valid === 1'b1) q.push_back(sysq_word);
      tick();
    end
    wait fork;
    chk_val("words", 96'hc, q.size());
    for (n = 0; n < q.size(); n++) begin
      b = a[n / 4];
      e = {b[31:5], b[4:3] + 2'(n % 4), 3'h0, b, 32'(n % 4)};
      chk_val("word", e, {q[n][95:67], 3'h0, q[n][63:0]});
    end
  endtask

  task automatic t_term(input logic err);
    tag_hit = ~err;
    sys_error = err;
    retry_req_in = ~err;
    pm.xfer(32'h0004_0008, 1'b1, 1'b1);
    sys_error = 1'b0;
    retry_req_in = 1'b0;
    chk_bit("error end", err, pm.got_err);
    chk_bit("retry end", ~err, pm.got_retry);
    chk_val("ended beats", 96'h0, pm.beats_done);
  endtask

  // A read start must be ignored
  task automatic t_read;
    pm.xfer(32'h0006_0000, 1'b1, 1'b0);
    repeat (4) begin
      tick();
      chk_val("read idle", 96'h0, outs());
    end
  endtask

  initial begin
    #1;
    t_reset();
    t_hit(32'h0000_1230, 1'b1);
    t_hit(32'h0000_4418, 1'b0);
    t_hit(32'h0000_2208, 1'b1);
    t_miss_fill();
    t_term(1'b1);
    t_term(1'b0);
    t_read();
    close_out();
  end
endmodule
`default_nettype wire
